// ==== uap_pkg.sv ====
// Function
// RQ1: capability field reports host-or-device value 0x2
// RQ2: host-role bit low means device-mode layout
// RQ3: 7-bit read/write address, bit 7 zero
// RQ4: software loads address assigned by host
// RQ5: device compares token address with stored address
// RQ6: power register resets 0x20, bits 5:4 read 0x2
// RQ7: host drives bus reset while bit 3 set
// RQ8: resume bit drives resume while bus suspended
// RQ9: host software clears resume after 20 ms
// RQ10: host suspend bit: write 1 suspends, 0 ignored
// RQ11: bit 0 powers down the transceiver
// RQ12: iso update holds ready packet until SOF
// RQ13: IN before awaited SOF sends zero-length packet
// RQ14: bit 6 enables or tri-states line drivers
// RQ15: device bit 3 reads bus reset presence
// RQ16: device software clears resume after 10-15 ms
// RQ17: suspend flag set on entry, cleared by read/resume
// RQ18: reserved and read-only bits ignore writes
package uap_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int FA_W = 7;
    localparam int IRQ_W = 3;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_FUNC_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_POWER = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CAPABILITY = 4'h5;
    // power register fields
    localparam int PWR_PHY_DOWN = 0;
    localparam int PWR_SUSPEND = 1;
    localparam int PWR_RESUME = 2;
    localparam int PWR_RESET = 3;
    localparam int PWR_SOFT_CONN = 6;
    localparam int PWR_ISO_WAIT = 7;
    localparam logic [1:0] PWR_DEV_RSVD = 2'h2;
    localparam logic [3:0] PWR_HOST_RSVD = 4'h2;
    localparam logic [DATA_W-1:0] PWR_RESET_VAL = 8'h20;
    localparam logic [DATA_W-1:0] FADDR_RESET_VAL = 8'h00;
    // capability field
    localparam logic [1:0] CAP_HOST_OR_DEVICE = 2'h2;
    // interrupt status bits
    localparam int IRQ_BUS_RESET = 0;
    localparam int IRQ_SUSPEND = 1;
    localparam int IRQ_ZERO_LEN = 2;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 3'h0;
    typedef enum logic [1:0] {
        UAP_ISO_IDLE,
        UAP_ISO_WAIT_SOF,
        UAP_ISO_ARMED
    } uap_iso_state_t;
endpackage

// ==== uap_addr_power.sv ====
`timescale 1ns/10ps
module uap_addr_power (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [uap_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [uap_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [uap_pkg::DATA_W-1:0] reg_rdata,
    // neighbouring controller state
    input wire logic host_role,
    input wire logic intr_reg_read,
    input wire logic transmit_packet_ready,
    input wire logic iso_endpoint,
    // bus line events
    input wire logic bus_reset_seen,
    input wire logic suspend_entry,
    input wire logic token_valid,
    input wire logic token_is_sof,
    input wire logic token_is_in,
    input wire logic [uap_pkg::FA_W-1:0] token_addr,
    // bus side controls
    output logic addr_match,
    output logic drive_bus_reset,
    output logic drive_resume,
    output logic bus_suspended,
    output logic transceiver_power_down,
    output logic line_drive_en,
    output logic send_packet,
    output logic send_zero_length,
    // interrupt
    output logic irq
);
    import uap_pkg::*;

    logic [FA_W-1:0] assigned_address_field_reg;
    logic transceiver_power_down_reg;
    logic suspend_reg;
    logic resume_reg;
    logic host_reset_reg;
    logic line_soft_connect_reg;
    logic iso_wait_for_frame_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic [IRQ_W-1:0] irq_status_next;
    logic bus_reset_seen_reg;
    logic line_suspended_reg;
    uap_iso_state_t iso_state_reg;
    uap_iso_state_t iso_state_next;
    logic send_packet_next;
    logic send_zero_next;
    logic wr_func;
    logic wr_power;
    logic in_to_us;
    logic [DATA_W-1:0] power_view;
    logic [DATA_W-1:0] read_next;

    assign wr_func = reg_wr && (reg_addr == OFS_FUNC_ADDR);
    assign wr_power = reg_wr && (reg_addr == OFS_POWER);
    assign in_to_us = !host_role && token_valid && token_is_in
        && (token_addr == assigned_address_field_reg); // RQ5

    // function address store
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            assigned_address_field_reg <= FADDR_RESET_VAL[FA_W-1:0];
        end else if (wr_func) begin
            assigned_address_field_reg <= reg_wdata[FA_W-1:0]; // RQ3 RQ4
        end
    end

    // power and resume bits common to both modes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            transceiver_power_down_reg <= PWR_RESET_VAL[PWR_PHY_DOWN];
            resume_reg <= PWR_RESET_VAL[PWR_RESUME];
        end else if (wr_power) begin
            transceiver_power_down_reg <= reg_wdata[PWR_PHY_DOWN]; // RQ11
            resume_reg <= reg_wdata[PWR_RESUME]; // RQ8
        end
    end

    // mode-specific writable bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            host_reset_reg <= PWR_RESET_VAL[PWR_RESET];
            line_soft_connect_reg <= PWR_RESET_VAL[PWR_SOFT_CONN];
            iso_wait_for_frame_reg <= PWR_RESET_VAL[PWR_ISO_WAIT];
        end else if (wr_power) begin
            if (host_role) begin
                host_reset_reg <= reg_wdata[PWR_RESET]; // RQ7
            end else begin
                line_soft_connect_reg <= reg_wdata[PWR_SOFT_CONN]; // RQ14
                iso_wait_for_frame_reg <= reg_wdata[PWR_ISO_WAIT]; // RQ12
            end
        end
    end

    // suspend: host write-one-to-set, device hardware flag
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            suspend_reg <= PWR_RESET_VAL[PWR_SUSPEND];
        end else if (host_role) begin
            if (wr_power && reg_wdata[PWR_SUSPEND]) begin
                suspend_reg <= 1'b1; // RQ10
            end else if (resume_reg && wr_power && !reg_wdata[PWR_RESUME]) begin
                suspend_reg <= 1'b0;
            end
        end else if (suspend_entry) begin
            suspend_reg <= 1'b1; // RQ17
        end else if (intr_reg_read || (wr_power && reg_wdata[PWR_RESUME])) begin
            suspend_reg <= 1'b0; // RQ17
        end
    end

    // line stays suspended until resume signalling ends or a bus reset is seen
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            line_suspended_reg <= 1'b0;
        end else if (host_role) begin
            line_suspended_reg <= 1'b0;
        end else if (suspend_entry) begin
            line_suspended_reg <= 1'b1; // RQ8
        end else if (bus_reset_seen || (wr_power && resume_reg && !reg_wdata[PWR_RESUME])) begin
            line_suspended_reg <= 1'b0;
        end
    end

    // line state sample
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_reset_seen_reg <= 1'b0;
        end else begin
            bus_reset_seen_reg <= bus_reset_seen && !host_role; // RQ15
        end
    end

    // isochronous send timing
    always_comb begin
        iso_state_next = iso_state_reg;
        send_packet_next = 1'b0;
        send_zero_next = 1'b0;
        case (iso_state_reg)
            UAP_ISO_IDLE: begin
                if (!host_role && transmit_packet_ready) begin
                    if (iso_wait_for_frame_reg && iso_endpoint) begin
                        iso_state_next = UAP_ISO_WAIT_SOF; // RQ12
                        send_zero_next = in_to_us; // RQ13
                    end else if (in_to_us) begin
                        send_packet_next = 1'b1;
                    end
                end
            end
            UAP_ISO_WAIT_SOF: begin
                if (!transmit_packet_ready || host_role) begin
                    iso_state_next = UAP_ISO_IDLE;
                end else if (token_valid && token_is_sof) begin
                    iso_state_next = UAP_ISO_ARMED; // RQ12
                end else if (in_to_us) begin
                    send_zero_next = 1'b1; // RQ13
                end
            end
            UAP_ISO_ARMED: begin
                if (!transmit_packet_ready || host_role) begin
                    iso_state_next = UAP_ISO_IDLE;
                end else if (in_to_us) begin
                    send_packet_next = 1'b1;
                    iso_state_next = UAP_ISO_IDLE;
                end
            end
            default: begin
                iso_state_next = UAP_ISO_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            iso_state_reg <= UAP_ISO_IDLE;
            send_packet <= 1'b0;
            send_zero_length <= 1'b0;
        end else begin
            iso_state_reg <= iso_state_next;
            send_packet <= send_packet_next;
            send_zero_length <= send_zero_next;
        end
    end

    // bus side outputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_match <= 1'b0;
            drive_bus_reset <= 1'b0;
            drive_resume <= 1'b0;
            bus_suspended <= 1'b0;
            transceiver_power_down <= 1'b0;
            line_drive_en <= 1'b0;
        end else begin
            addr_match <= !host_role && token_valid
                && (token_addr == assigned_address_field_reg); // RQ5
            drive_bus_reset <= host_role && host_reset_reg; // RQ7
            drive_resume <= resume_reg && (suspend_reg || line_suspended_reg); // RQ8
            bus_suspended <= suspend_reg;
            transceiver_power_down <= transceiver_power_down_reg; // RQ11
            line_drive_en <= host_role || line_soft_connect_reg; // RQ14
        end
    end

    // interrupt status, set wins over clear
    always_comb begin
        irq_status_next = irq_status_reg;
        if (reg_wr && (reg_addr == OFS_IRQ_CLEAR)) begin
            irq_status_next = irq_status_reg & ~reg_wdata[IRQ_W-1:0];
        end
        if (bus_reset_seen && !host_role && !bus_reset_seen_reg) begin
            irq_status_next[IRQ_BUS_RESET] = 1'b1;
        end
        if (suspend_entry && !host_role) begin
            irq_status_next[IRQ_SUSPEND] = 1'b1;
        end
        if (send_zero_next) begin
            irq_status_next[IRQ_ZERO_LEN] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_status_reg <= '0;
            irq_enable_reg <= IRQ_ENABLE_RESET;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (reg_wr && (reg_addr == OFS_IRQ_ENABLE)) begin
                irq_enable_reg <= reg_wdata[IRQ_W-1:0];
            end
            irq <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // register read path
    always_comb begin
        if (host_role) begin
            power_view = {PWR_HOST_RSVD, host_reset_reg, resume_reg, suspend_reg,
                transceiver_power_down_reg}; // RQ2 RQ6 RQ18
        end else begin
            power_view = {iso_wait_for_frame_reg, line_soft_connect_reg, PWR_DEV_RSVD,
                bus_reset_seen_reg, resume_reg, suspend_reg,
                transceiver_power_down_reg}; // RQ2 RQ6 RQ15
        end
        read_next = '0;
        if (reg_addr == OFS_FUNC_ADDR) begin
            read_next = {1'b0, assigned_address_field_reg}; // RQ3 RQ18
        end else if (reg_addr == OFS_POWER) begin
            read_next = power_view;
        end else if (reg_addr == OFS_IRQ_STATUS) begin
            read_next = {{(DATA_W-IRQ_W){1'b0}}, irq_status_reg};
        end else if (reg_addr == OFS_IRQ_ENABLE) begin
            read_next = {{(DATA_W-IRQ_W){1'b0}}, irq_enable_reg};
        end else if (reg_addr == OFS_CAPABILITY) begin
            read_next = {{(DATA_W-2){1'b0}}, CAP_HOST_OR_DEVICE}; // RQ1
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= read_next;
        end else begin
            reg_rdata <= '0;
        end
    end

    // checks
    sequence s_rd_power_dev;
        reg_rd && (reg_addr == OFS_POWER) && !host_role;
    endsequence
    sequence s_waiting_in;
        (iso_state_reg == UAP_ISO_WAIT_SOF) && transmit_packet_ready && !host_role
            && !(token_valid && token_is_sof) ##0 in_to_us;
    endsequence
    sequence s_rd_power_host;
        reg_rd && (reg_addr == OFS_POWER) && host_role;
    endsequence
    sequence s_iso_start;
        (iso_state_reg == UAP_ISO_IDLE) && !host_role && transmit_packet_ready
            && iso_wait_for_frame_reg && iso_endpoint;
    endsequence
    sequence s_armed_in;
        (iso_state_reg == UAP_ISO_ARMED) && transmit_packet_ready && !host_role ##0 in_to_us;
    endsequence

    AST_CAPABILITY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
        reg_rd && (reg_addr == OFS_CAPABILITY) |=> reg_rdata == 8'h02)
        else $error("capability field wrong");
    AST_FADDR_TOP_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
        reg_wr && (reg_addr == OFS_FUNC_ADDR) ##1 reg_rd && (reg_addr == OFS_FUNC_ADDR)
        |=> reg_rdata == {1'b0, $past(reg_wdata[FA_W-1:0], 2)})
        else $error("function address readback wrong");
    AST_POWER_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
        s_rd_power_dev |=> reg_rdata[5:4] == 2'h2)
        else $error("reserved power bits wrong");
    AST_HOST_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
        host_role && host_reset_reg |=> drive_bus_reset)
        else $error("bus reset not driven");
    AST_RESUME: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
        resume_reg && (suspend_reg || line_suspended_reg) |=> drive_resume)
        else $error("resume not driven");
    AST_SUSPEND_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
        host_role && wr_power && reg_wdata[PWR_SUSPEND] |=> suspend_reg ##1 bus_suspended)
        else $error("suspend write not taken");
    AST_PHY_DOWN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
        wr_power |=> ##1 transceiver_power_down == $past(reg_wdata[PWR_PHY_DOWN], 2))
        else $error("transceiver power control wrong");
    AST_ISO_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
        iso_state_reg == UAP_ISO_WAIT_SOF |=> !send_packet)
        else $error("packet sent before frame start");
    AST_ISO_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
        s_waiting_in |=> send_zero_length && !send_packet)
        else $error("zero-length packet missing");
    AST_SOFT_CONN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
        !host_role && !line_soft_connect_reg |=> !line_drive_en)
        else $error("lines driven while disconnected");
    AST_RESET_SEEN: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
        s_rd_power_dev |=> reg_rdata[PWR_RESET] == $past(bus_reset_seen_reg))
        else $error("bus reset flag readback wrong");
    AST_SUSP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
        !host_role && intr_reg_read && !suspend_entry |=> !suspend_reg)
        else $error("suspend flag not cleared");
    AST_ADDR_MATCH: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5
        !host_role && token_valid && (token_addr == assigned_address_field_reg)
        |=> addr_match)
        else $error("address match missed");
    AST_FADDR_READ: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
        reg_rd && (reg_addr == OFS_FUNC_ADDR) |=> !reg_rdata[DATA_W-1])
        else $error("reserved address bit not zero");
    AST_HOST_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
        s_rd_power_host |=> reg_rdata[DATA_W-1:PWR_RESET+1] == PWR_HOST_RSVD)
        else $error("host reserved power bits wrong");
    AST_HOST_RESET_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
        !(host_role && host_reset_reg) |=> !drive_bus_reset)
        else $error("bus reset driven without request");
    AST_RESUME_END: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
        !resume_reg |=> !drive_resume)
        else $error("resume driven after bit cleared");
    AST_SUSPEND_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
        host_role && wr_power && !reg_wdata[PWR_SUSPEND] && !resume_reg && suspend_reg
        |=> suspend_reg)
        else $error("suspend cleared by zero write");
    AST_SOFT_CONN_ON: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
        !host_role && line_soft_connect_reg |=> line_drive_en)
        else $error("lines not driven while connected");
    AST_RESET_SEEN_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
        !host_role && bus_reset_seen |=> bus_reset_seen_reg)
        else $error("bus reset presence not flagged");
    AST_SUSP_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
        !host_role && suspend_entry |=> suspend_reg)
        else $error("suspend flag not set");
    AST_SUSP_RESUME_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
        !host_role && wr_power && reg_wdata[PWR_RESUME] && !suspend_entry |=> !suspend_reg)
        else $error("suspend flag not cleared by resume");
    AST_HOST_NO_SEND: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
        host_role |=> !addr_match && !send_packet && !send_zero_length)
        else $error("device response in host mode");
    AST_ISO_WAIT_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
        s_iso_start |=> iso_state_reg == UAP_ISO_WAIT_SOF)
        else $error("ready packet not held for frame start");
    AST_ISO_SEND: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
        s_armed_in |=> send_packet && !send_zero_length)
        else $error("armed packet not sent");
    AST_DEV_RESET_RO: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ18
        !host_role && wr_power |=> $stable(host_reset_reg))
        else $error("read-only reset bit written");
    AST_HOST_DEV_BITS_RO: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ18
        host_role && wr_power |=> $stable(iso_wait_for_frame_reg) && $stable(line_soft_connect_reg))
        else $error("device-only bits written in host mode");
endmodule // uap_addr_power

// ==== uap_remote_host.sv ====
`timescale 1ns/10ps
module uap_remote_host (
    // clock
    input wire logic sys_clk,
    // bus line events toward the block
    output logic bus_reset_seen,
    output logic suspend_entry,
    output logic token_valid,
    output logic token_is_sof,
    output logic token_is_in,
    output logic [uap_pkg::FA_W-1:0] token_addr
);
    import uap_pkg::*;
    initial begin
        bus_reset_seen = 1'b0;
        suspend_entry = 1'b0;
        token_valid = 1'b0;
        token_is_sof = 1'b0;
        token_is_in = 1'b0;
        token_addr = 7'h55;
    end
    // one token; address inverted once it is no longer qualified
    task automatic token(input logic sof, input logic in_tok, input logic [FA_W-1:0] a);
        @(posedge sys_clk);
        token_valid <= 1'b1;
        token_is_sof <= sof;
        token_is_in <= in_tok;
        token_addr <= a;
        @(posedge sys_clk);
        token_valid <= 1'b0;
        token_is_sof <= 1'b0;
        token_is_in <= 1'b0;
        token_addr <= ~a;
        #1;
    endtask
    // reset signalling level on the bus
    task automatic bus_reset(input logic on);
        @(posedge sys_clk);
        bus_reset_seen <= on;
    endtask
    // bus went idle long enough to suspend
    task automatic suspend();
        @(posedge sys_clk);
        suspend_entry <= 1'b1;
        @(posedge sys_clk);
        suspend_entry <= 1'b0;
    endtask
endmodule // uap_remote_host

// ==== uap_addr_power_tb.sv ====
`timescale 1ns/10ps
module uap_addr_power_tb;
    import uap_pkg::*;
    logic sys_clk, rst_n, reg_wr, reg_rd, host_role, intr_reg_read;
    logic transmit_packet_ready, iso_endpoint;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic bus_reset_seen, suspend_entry, token_valid, token_is_sof, token_is_in;
    logic [FA_W-1:0] token_addr;
    logic addr_match, drive_bus_reset, drive_resume, bus_suspended;
    logic transceiver_power_down, line_drive_en, send_packet, send_zero_length, irq;
    int mismatches, comparisons;

    uap_addr_power DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .host_role, .intr_reg_read, .transmit_packet_ready, .iso_endpoint,
        .bus_reset_seen, .suspend_entry, .token_valid, .token_is_sof, .token_is_in,
        .token_addr, .addr_match, .drive_bus_reset, .drive_resume, .bus_suspended,
        .transceiver_power_down, .line_drive_en, .send_packet, .send_zero_length, .irq);

    uap_remote_host u_host (.sys_clk, .bus_reset_seen, .suspend_entry, .token_valid,
        .token_is_sof, .token_is_in, .token_addr);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bit_chk(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_irq(input logic exp);
        int n;
        n = 0;
        while (irq !== exp && n < 8) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        bit_chk(irq, exp);
        if (irq !== exp) report_and_stop();
    endtask

    task automatic t_regs();
        rd(OFS_FUNC_ADDR, 8'h00);
        rd(OFS_POWER, 8'h20);
        @(posedge sys_clk);
        #1;
        chk(reg_rdata, 8'h00);
        rd(OFS_CAPABILITY, 8'h02);
        rd(4'hF, 8'h00);
        wr_rd(OFS_FUNC_ADDR, 8'hAA, 8'h2A);
        wr(OFS_FUNC_ADDR, 8'hFF);
        rd(OFS_FUNC_ADDR, 8'h7F);
        wr(OFS_CAPABILITY, 8'h00);
        rd(OFS_CAPABILITY, 8'h02);
    endtask
    task automatic t_dev_power();
        wr(OFS_POWER, 8'hFF);
        rd(OFS_POWER, 8'hE5);
        bit_chk(line_drive_en, 1'b1);
        bit_chk(transceiver_power_down, 1'b1);
        wr(OFS_POWER, 8'h00);
        rd(OFS_POWER, 8'h20);
        bit_chk(line_drive_en, 1'b0);
        bit_chk(transceiver_power_down, 1'b0);
    endtask
    task automatic t_dev_events();
        wr(OFS_IRQ_ENABLE, 8'h07);
        u_host.bus_reset(1'b1);
        rd(OFS_POWER, 8'h28);
        wait_irq(1'b1);
        rd(OFS_IRQ_STATUS, 8'h01);
        u_host.bus_reset(1'b0);
        rd(OFS_POWER, 8'h20);
        wr(OFS_IRQ_CLEAR, 8'h07);
        wait_irq(1'b0);
        wr(OFS_IRQ_ENABLE, 8'h00);
        u_host.suspend();
        rd(OFS_IRQ_STATUS, 8'h02);
        bit_chk(irq, 1'b0);
        rd(OFS_POWER, 8'h22);
        @(posedge sys_clk);
        intr_reg_read <= 1'b1;
        @(posedge sys_clk);
        intr_reg_read <= 1'b0;
        rd(OFS_POWER, 8'h20);
        wr(OFS_IRQ_ENABLE, 8'h02);
        wait_irq(1'b1);
        wr(OFS_IRQ_CLEAR, 8'h02);
        wait_irq(1'b0);
        u_host.suspend();
        wr(OFS_POWER, 8'h04);
        rd(OFS_POWER, 8'h24);
        bit_chk(drive_resume, 1'b1);
        wr(OFS_POWER, 8'h00);
        rd(OFS_POWER, 8'h20);
        bit_chk(drive_resume, 1'b0);
        wr(OFS_IRQ_CLEAR, 8'h07);
    endtask
    task automatic t_host();
        host_role <= 1'b1;
        wr(OFS_POWER, 8'hF8);
        rd(OFS_POWER, 8'h28);
        bit_chk(drive_bus_reset, 1'b1);
        wr(OFS_POWER, 8'h00);
        rd(OFS_POWER, 8'h20);
        bit_chk(drive_bus_reset, 1'b0);
        wr(OFS_POWER, 8'h02);
        rd(OFS_POWER, 8'h22);
        bit_chk(bus_suspended, 1'b1);
        wr(OFS_POWER, 8'h00);
        rd(OFS_POWER, 8'h22);
        wr(OFS_POWER, 8'h06);
        rd(OFS_POWER, 8'h26);
        bit_chk(drive_resume, 1'b1);
        wr(OFS_POWER, 8'h00);
        rd(OFS_POWER, 8'h20);
        bit_chk(drive_resume, 1'b0);
        u_host.token(1'b0, 1'b1, 7'h7F);
        bit_chk(addr_match, 1'b0);
        @(posedge sys_clk);
        host_role <= 1'b0;
    endtask
    task automatic t_tokens();
        wr(OFS_FUNC_ADDR, 8'h15);
        u_host.token(1'b0, 1'b1, 7'h15);
        bit_chk(addr_match, 1'b1);
        u_host.token(1'b0, 1'b1, 7'h16);
        bit_chk(addr_match, 1'b0);
        @(posedge sys_clk);
        transmit_packet_ready <= 1'b1;
        u_host.token(1'b0, 1'b1, 7'h15);
        bit_chk(send_packet, 1'b1);
        @(posedge sys_clk);
        transmit_packet_ready <= 1'b0;
        wr(OFS_POWER, 8'h80);
        iso_endpoint <= 1'b1;
        transmit_packet_ready <= 1'b1;
        u_host.token(1'b0, 1'b1, 7'h15);
        bit_chk(send_zero_length, 1'b1);
        bit_chk(send_packet, 1'b0);
        rd(OFS_IRQ_STATUS, 8'h04);
        u_host.token(1'b1, 1'b0, 7'h00);
        bit_chk(send_packet, 1'b0);
        u_host.token(1'b0, 1'b1, 7'h15);
        bit_chk(send_packet, 1'b1);
        bit_chk(send_zero_length, 1'b0);
        transmit_packet_ready <= 1'b0;
        iso_endpoint <= 1'b0;
    endtask

    initial begin
        mismatches = 0;
        comparisons = 0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        host_role = 1'b0;
        intr_reg_read = 1'b0;
        transmit_packet_ready = 1'b0;
        iso_endpoint = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_dev_power();
        t_dev_events();
        t_host();
        t_tokens();
        report_and_stop();
    end
endmodule // uap_addr_power_tb
